/* File: src/trap_cfg.svh */
/*
 * register offsets, field positions, codes and reset values of the
 * machine trap unit; included by every file that needs a number.
 * assumes nothing but a preprocessor.
 */
`ifndef TRAP_CFG_SVH
`define TRAP_CFG_SVH

// ==========================================
// register offsets on the plain register port
`define OFS_STATUS 8'h00
`define OFS_VECTOR 8'h04
`define OFS_ENABLE 8'h08
`define OFS_PENDING 8'h0c
`define OFS_CAUSE 8'h10
`define OFS_RET_PC 8'h14
`define OFS_PRIV 8'h18

// ==========================================
// status field positions
`define ST_GLOBAL_EN 3
`define ST_PRIOR_EN 7
`define ST_PRIOR_PRIV_HI 12
`define ST_PRIOR_PRIV_LO 11

// ==========================================
// enable and pending bit positions
`define IRQ_SOFT_BIT 3
`define IRQ_TIMER_BIT 7
`define IRQ_EXT_BIT 11

// ==========================================
// index of each source in the internal 3-bit vectors
`define SRC_SOFT 0
`define SRC_TIMER 1
`define SRC_EXT 2

// ==========================================
// cause codes and cause layout
`define CODE_SOFT 10'h003
`define CODE_TIMER 10'h007
`define CODE_EXT 10'h00b
`define CAUSE_IRQ_BIT 31

// ==========================================
// vector modes and privilege codes
`define MODE_DIRECT 2'h0
`define MODE_VECTORED 2'h1
`define PRIV_MACHINE 2'h3

// ==========================================
// reset values
`define RST_WORD 32'h0000_0000
`define RST_MODE 2'h0
`define RST_BASE 30'h0000_0000

`endif

/* File: src/trap_pkg.sv */
/*
 * types shared by the machine trap unit.
 * assumes trap_cfg.svh for numbers.
 */
package trap_pkg;

   // ==========================================
   // trap sequencing states, one-hot
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_latch = 4'b0010,
      st_target = 4'b0100,
      st_issue = 4'b1000
   } seq_state_t;

   typedef logic [1:0] priv_t;
   typedef logic [9:0] code_t;

endpackage : trap_pkg

/* File: src/irq_sel_if.sv */
/*
 * carries pending, enables and the selected interrupt between the trap
 * unit and its priority selector.
 * assumes one clock; the selector is purely combinational.
 */
`timescale 1ns/1ps

interface irq_sel_if;
   logic [2:0] pending;
   logic [2:0] enable;
   logic global_en;
   logic take;
   trap_pkg::code_t code;

   modport core (output pending, output enable, output global_en,
                 input take, input code);
   modport sel (input pending, input enable, input global_en,
                output take, output code);
endinterface : irq_sel_if

/* File: src/irq_line_sync.sv */
/*
 * two flip-flop synchroniser for the interrupt source lines.
 * assumes the lines are levels from another domain.
 */
`timescale 1ns/1ps

module irq_line_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // lines
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // ==========================================
   // two stages, first read only by the second
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         stage1 <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : irq_line_sync

/* File: src/irq_priority_sel.sv */
/*
 * picks the interrupt to take: external, then software, then timer.
 * assumes pending and enables are already in the core clock domain.
 */
`timescale 1ns/1ps
`include "trap_cfg.svh"

module irq_priority_sel (
   // selection link
   irq_sel_if.sel link
);

   logic [2:0] ready;

   // ==========================================
   // gating and fixed priority
   always_comb begin
      ready = link.pending & link.enable;
      link.take = link.global_en && (ready != 3'h0);
      link.code = `CODE_TIMER;
      if (ready[`SRC_EXT]) begin
         link.code = `CODE_EXT;
      end else if (ready[`SRC_SOFT]) begin
         link.code = `CODE_SOFT;
      end
   end

endmodule : irq_priority_sel

/* File: src/machine_trap_entry_exit.sv */
/*
 * machine-mode trap entry and return for a single hart: status, vector,
 * enable, pending, cause and return pc registers, interrupt gating,
 * priority, vector target and pipeline redirect.
 * assumes the pipeline holds a request while trap_busy is high and that
 * source lines arrive asynchronously.
 */
// The register addresses and strobed register access were decided locally.
// How it works
// - global enable clear blocks every interrupt
// - enabled pending interrupt preempts when globally enabled
// - any trap enters machine mode, clears enable
// - copy global enable to prior, then clear
// - save prior privilege in status
// - save pc, then jump by vector mode
// - return restores privilege, enable and pc
// - status bits 3, 7, 12:11 read-write
// - take only if global and source enabled
// - vector holds mode 1:0, base 31:2
// - direct mode: every trap goes to base
// - vectored interrupts go base plus four causes
// - external interrupt uses cause code eleven
// - enable bits 3, 7, 11 read-write
// - pending bits 3, 7, 11 read-only
// - pending follows sources, writes ignored
// - priority external, software, then timer
// - interrupt cause: top bit set, number low
// - handler fetch four cycles after signalling
`timescale 1ns/1ps
`include "trap_cfg.svh"

module machine_trap_entry_exit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // interrupt source lines
   input wire logic soft_irq_line,
   input wire logic timer_irq_line,
   input wire logic ext_irq_line,
   // pipeline requests
   input wire logic [31:0] cur_pc,
   input wire logic exc_req,
   input wire logic [9:0] exc_code,
   input wire logic ret_req,
   // pipeline answers
   output logic redirect_valid,
   output logic [31:0] redirect_pc,
   output logic trap_busy,
   output logic [1:0] priv_mode
);

   // ==========================================
   // declarations
   trap_pkg::seq_state_t state;
   trap_pkg::seq_state_t next_state;
   logic [2:0] src_sync;
   logic global_en;
   logic prior_irq_enable;
   trap_pkg::priv_t prior_privilege;
   logic [1:0] vec_mode;
   logic [29:0] vec_base;
   logic soft_irq_enable;
   logic timer_irq_enable;
   logic ext_irq_enable;
   logic [31:0] cause;
   logic [31:0] ret_pc;
   logic [31:0] target;
   logic trap_is_irq;
   trap_pkg::code_t cause_code;
   logic enter_exc;
   logic enter_irq;
   logic enter;
   logic leave;
   logic wr_status;
   logic wr_vector;
   logic wr_enable;
   logic wr_cause;
   logic wr_ret_pc;

   irq_sel_if sel_link ();

   // ==========================================
   // functions
   function automatic logic [31:0] irq_word(input logic [2:0] bits);
      logic [31:0] w;
      w = `RST_WORD;
      w[`IRQ_SOFT_BIT] = bits[`SRC_SOFT];
      w[`IRQ_TIMER_BIT] = bits[`SRC_TIMER];
      w[`IRQ_EXT_BIT] = bits[`SRC_EXT];
      return w;
   endfunction : irq_word

   function automatic logic [31:0] vec_target(
      input logic [29:0] base,
      input logic [1:0] mode,
      input logic is_irq,
      input trap_pkg::code_t code
   );
      logic [31:0] t;
      t = {base, 2'h0};
      if (is_irq && mode == `MODE_VECTORED) begin
         t = t + {20'h00000, code, 2'h0};
      end
      return t;
   endfunction : vec_target

   // ==========================================
   // source synchronisers and priority selector
   irq_line_sync #(
      .WIDTH(3)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_in({ext_irq_line, timer_irq_line, soft_irq_line}),
      .sync_out(src_sync)
   );

   assign sel_link.pending = src_sync;
   assign sel_link.enable = {ext_irq_enable, timer_irq_enable,
                             soft_irq_enable};
   assign sel_link.global_en = global_en;

   irq_priority_sel u_sel (
      .link(sel_link)
   );

   // ==========================================
   // request decode
   always_comb begin
      enter_exc = (state == trap_pkg::st_idle) && exc_req;
      enter_irq = (state == trap_pkg::st_idle) && !exc_req && !ret_req &&
                  sel_link.take;
      enter = enter_exc || enter_irq;
      leave = (state == trap_pkg::st_idle) && !exc_req && ret_req;
      wr_status = reg_wr && reg_addr == `OFS_STATUS;
      wr_vector = reg_wr && reg_addr == `OFS_VECTOR;
      wr_enable = reg_wr && reg_addr == `OFS_ENABLE;
      wr_cause = reg_wr && reg_addr == `OFS_CAUSE;
      wr_ret_pc = reg_wr && reg_addr == `OFS_RET_PC;
   end

   // ==========================================
   // sequencer
   always_comb begin
      case (state)
         trap_pkg::st_idle: begin
            if (enter) begin
               next_state = trap_pkg::st_latch;
            end else if (leave) begin
               next_state = trap_pkg::st_issue;
            end else begin
               next_state = trap_pkg::st_idle;
            end
         end
         trap_pkg::st_latch: begin
            next_state = trap_pkg::st_target;
         end
         trap_pkg::st_target: begin
            next_state = trap_pkg::st_issue;
         end
         trap_pkg::st_issue: begin
            next_state = trap_pkg::st_idle;
         end
         default: begin
            next_state = trap_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= trap_pkg::st_idle;
         trap_busy <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         trap_busy <= next_state != trap_pkg::st_idle;
      end
   end

   // ==========================================
   // global enable, prior enable, prior privilege
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         global_en <= 1'b0;
         prior_irq_enable <= 1'b0;
         prior_privilege <= `PRIV_MACHINE;
      end else if (clk_en) begin
         if (enter) begin
            prior_irq_enable <= global_en;
            global_en <= 1'b0;
            prior_privilege <= priv_mode;
         end else if (leave) begin
            global_en <= prior_irq_enable;
            prior_irq_enable <= 1'b1;
         end else if (wr_status) begin
            global_en <= reg_wdata[`ST_GLOBAL_EN];
            prior_irq_enable <= reg_wdata[`ST_PRIOR_EN];
            prior_privilege <=
               reg_wdata[`ST_PRIOR_PRIV_HI:`ST_PRIOR_PRIV_LO];
         end
      end
   end

   // ==========================================
   // current privilege
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         priv_mode <= `PRIV_MACHINE;
      end else if (clk_en) begin
         if (enter) begin
            priv_mode <= `PRIV_MACHINE;
         end else if (leave) begin
            priv_mode <= prior_privilege;
         end
      end
   end

   // ==========================================
   // trap vector
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         vec_mode <= `RST_MODE;
         vec_base <= `RST_BASE;
      end else if (clk_en && wr_vector) begin
         vec_base <= reg_wdata[31:2];
         if (reg_wdata[1:0] == `MODE_DIRECT ||
             reg_wdata[1:0] == `MODE_VECTORED) begin
            vec_mode <= reg_wdata[1:0];
         end
      end
   end

   // ==========================================
   // individual enables
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         soft_irq_enable <= 1'b0;
         timer_irq_enable <= 1'b0;
         ext_irq_enable <= 1'b0;
      end else if (clk_en && wr_enable) begin
         soft_irq_enable <= reg_wdata[`IRQ_SOFT_BIT];
         timer_irq_enable <= reg_wdata[`IRQ_TIMER_BIT];
         ext_irq_enable <= reg_wdata[`IRQ_EXT_BIT];
      end
   end

   // ==========================================
   // cause and return pc
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cause <= `RST_WORD;
         trap_is_irq <= 1'b0;
         cause_code <= `CODE_SOFT;
      end else if (clk_en) begin
         if (enter_irq) begin
            cause <= `RST_WORD;
            cause[`CAUSE_IRQ_BIT] <= 1'b1;
            cause[9:0] <= sel_link.code;
            trap_is_irq <= 1'b1;
            cause_code <= sel_link.code;
         end else if (enter_exc) begin
            cause <= {22'h000000, exc_code};
            trap_is_irq <= 1'b0;
            cause_code <= exc_code;
         end else if (wr_cause) begin
            cause <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ret_pc <= `RST_WORD;
      end else if (clk_en) begin
         if (enter) begin
            ret_pc <= cur_pc;
         end else if (wr_ret_pc) begin
            ret_pc <= {reg_wdata[31:2], 2'h0};
         end
      end
   end

   // ==========================================
   // redirect target and issue
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         target <= `RST_WORD;
      end else if (clk_en) begin
         if (leave) begin
            target <= ret_pc;
         end else if (state == trap_pkg::st_latch) begin
            target <= vec_target(vec_base, vec_mode, trap_is_irq,
                                 cause_code);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         redirect_valid <= 1'b0;
         redirect_pc <= `RST_WORD;
      end else if (clk_en) begin
         redirect_valid <= state == trap_pkg::st_issue;
         if (state == trap_pkg::st_issue) begin
            redirect_pc <= target;
         end
      end
   end

   // ==========================================
   // register read, data in the following cycle only
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= `RST_WORD;
      end else if (clk_en) begin
         reg_rdata <= `RST_WORD;
         if (reg_rd) begin
            case (reg_addr)
               `OFS_STATUS: begin
                  reg_rdata[`ST_GLOBAL_EN] <= global_en;
                  reg_rdata[`ST_PRIOR_EN] <= prior_irq_enable;
                  reg_rdata[`ST_PRIOR_PRIV_HI:`ST_PRIOR_PRIV_LO] <=
                     prior_privilege;
               end
               `OFS_VECTOR: begin
                  reg_rdata <= {vec_base, vec_mode};
               end
               `OFS_ENABLE: begin
                  reg_rdata <= irq_word(sel_link.enable);
               end
               `OFS_PENDING: begin
                  reg_rdata <= irq_word(src_sync);
               end
               `OFS_CAUSE: begin
                  reg_rdata <= cause;
               end
               `OFS_RET_PC: begin
                  reg_rdata <= ret_pc;
               end
               `OFS_PRIV: begin
                  reg_rdata[1:0] <= priv_mode;
               end
               default: begin
                  reg_rdata <= `RST_WORD;
               end
            endcase
         end
      end
   end

endmodule : machine_trap_entry_exit

/* File: tb/trap_unit_checker_asserts.sv */
/*
 * concurrent checks of the machine trap unit, bound to its top module.
 * assumes clk_en stays high and the return pc is never written by software.
 */
`timescale 1ns/1ps
`include "trap_cfg.svh"

module trap_unit_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // sources and pipeline
   input wire logic soft_irq_line,
   input wire logic timer_irq_line,
   input wire logic ext_irq_line,
   input wire logic [31:0] cur_pc,
   input wire logic exc_req,
   input wire logic ret_req,
   input wire logic redirect_valid,
   input wire logic [31:0] redirect_pc,
   input wire logic trap_busy,
   input wire logic [1:0] priv_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ==========================================
   // shadows of the state software can see
   logic [11:0] pend_w;
   logic [11:0] en_q;
   logic [29:0] base_q;
   logic [31:0] epc_q;
   logic [31:0] pc_q;
   logic glob_q;
   logic prior_q;
   logic busy_q;
   logic ret_q;
   logic exc_q;
   logic entry;
   logic leave;
   assign pend_w = {ext_irq_line, 3'h0, timer_irq_line, 3'h0,
      soft_irq_line, 3'h0};
   assign entry = trap_busy && !busy_q && !ret_q;
   assign leave = trap_busy && !busy_q && ret_q;

   always_ff @(posedge ref_clk) begin
      busy_q <= trap_busy;
      ret_q <= ret_req && !exc_req;
      exc_q <= exc_req;
      pc_q <= cur_pc;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         en_q <= 12'h0;
         base_q <= 30'h0;
      end else if (reg_wr && reg_addr == `OFS_ENABLE) begin
         en_q <= reg_wdata[11:0] & 12'h888;
      end else if (reg_wr && reg_addr == `OFS_VECTOR) begin
         base_q <= reg_wdata[31:2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         glob_q <= 1'b0;
         prior_q <= 1'b0;
         epc_q <= 32'h0;
      end else if (entry) begin
         glob_q <= 1'b0;
         prior_q <= glob_q;
         epc_q <= {pc_q[31:2], 2'h0};
      end else if (leave) begin
         glob_q <= prior_q;
         prior_q <= 1'b1;
      end else if (reg_wr && reg_addr == `OFS_STATUS) begin
         glob_q <= reg_wdata[`ST_GLOBAL_EN];
         prior_q <= reg_wdata[`ST_PRIOR_EN];
      end
   end

   // ==========================================
   // properties
   property p_entry_seq;
      entry |-> trap_busy[*3] ##1 (redirect_valid && !trap_busy);
   endproperty
   a_entry_seq: assert property (p_entry_seq)
      else $error("trap entry redirect not four cycles after decision");

   property p_ret_seq;
      leave |-> ##1 (redirect_valid && !trap_busy && redirect_pc == epc_q);
   endproperty
   a_ret_seq: assert property (p_ret_seq)
      else $error("return did not redirect to the saved pc");

   property p_priv_entry;
      entry |-> priv_mode == `PRIV_MACHINE;
   endproperty
   a_priv_entry: assert property (p_priv_entry)
      else $error("trap entry left machine mode");

   property p_exc_target;
      entry && exc_q |-> ##3 redirect_pc == {base_q, 2'h0};
   endproperty
   a_exc_target: assert property (p_exc_target)
      else $error("exception did not go to the vector base");

   property p_pulse;
      redirect_valid |=> !redirect_valid;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("redirect pulse longer than one cycle");

   property p_busy_quiet;
      !trap_busy && !$past(trap_busy) |-> !redirect_valid;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("redirect without a trap sequence");

   property p_pending;
      reg_rd && reg_addr == `OFS_PENDING && $stable(pend_w)
         && pend_w == $past(pend_w, 2) && pend_w == $past(pend_w, 3)
         |=> reg_rdata == {20'h0, $past(pend_w)};
   endproperty
   a_pending: assert property (p_pending)
      else $error("pending word does not follow the source lines");

   property p_gate;
      entry && !exc_q |-> glob_q && ((en_q & (pend_w | $past(pend_w)
         | $past(pend_w, 2) | $past(pend_w, 3))) != 12'h0);
   endproperty
   a_gate: assert property (p_gate)
      else $error("interrupt taken while disabled");

   c_irq: cover property (entry && !exc_q);
   c_exc: cover property (entry && exc_q);
   c_ret: cover property (leave);
endmodule : trap_unit_checker

bind machine_trap_entry_exit trap_unit_checker chk_u (
   .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .soft_irq_line(soft_irq_line),
   .timer_irq_line(timer_irq_line), .ext_irq_line(ext_irq_line),
   .cur_pc(cur_pc), .exc_req(exc_req), .ret_req(ret_req),
   .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
   .trap_busy(trap_busy), .priv_mode(priv_mode));

/* File: tb/irq_source_model.sv */
/*
 * interrupt sources at the far side: software, timer and external lines.
 * assumes the bench asks for levels through want.
 */
`timescale 1ns/1ps

module irq_source_model (
   // clock
   input wire logic ref_clk,
   // requested levels: soft, timer, external
   input wire logic [2:0] want,
   // source lines
   output logic soft_irq_line,
   output logic timer_irq_line,
   output logic ext_irq_line
);
   // ==========================================
   // levels change after an edge and hold until withdrawn
   always_ff @(posedge ref_clk) begin
      soft_irq_line <= want[0];
      timer_irq_line <= want[1];
      ext_irq_line <= want[2];
   end
endmodule : irq_source_model

/* File: tb/test_machine_trap_entry_exit.sv */
/*
 * self-checking bench of the machine trap unit.
 * assumes the checker is bound and clk_en may stay high.
 */
`timescale 1ns/1ps
`include "trap_cfg.svh"

module test_machine_trap_entry_exit;
   logic ref_clk;
   logic reset_n;
   logic clk_en;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [2:0] want;
   logic soft_irq_line;
   logic timer_irq_line;
   logic ext_irq_line;
   logic [31:0] cur_pc;
   logic exc_req;
   logic [9:0] exc_code;
   logic ret_req;
   logic redirect_valid;
   logic [31:0] redirect_pc;
   logic trap_busy;
   logic [1:0] priv_mode;
   int n_mismatch;
   int num_checks;

   machine_trap_entry_exit dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .soft_irq_line(soft_irq_line), .timer_irq_line(timer_irq_line),
      .ext_irq_line(ext_irq_line), .cur_pc(cur_pc), .exc_req(exc_req),
      .exc_code(exc_code), .ret_req(ret_req),
      .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
      .trap_busy(trap_busy), .priv_mode(priv_mode));

   irq_source_model src_u (.ref_clk(ref_clk), .want(want),
      .soft_irq_line(soft_irq_line), .timer_irq_line(timer_irq_line),
      .ext_irq_line(ext_irq_line));

   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      check(what, reg_rdata, exp);
   endtask : rd

   task automatic wait_redirect(input string what, input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (redirect_valid !== 1'b1 && n < 40);
      check("redirect valid", {31'h0, redirect_valid}, 32'h1);
      check(what, redirect_pc, exp);
   endtask : wait_redirect

   task automatic quiet(input int cycles);
      int hits;
      hits = 0;
      repeat (cycles) begin
         @(posedge ref_clk);
         if (redirect_valid === 1'b1) hits++;
      end
      check("no redirect", hits, 32'h0);
   endtask : quiet

   task automatic do_ret(input logic [31:0] exp);
      @(posedge ref_clk);
      ret_req <= 1'b1;
      @(posedge ref_clk);
      ret_req <= 1'b0;
      wait_redirect("return pc", exp);
   endtask : do_ret

   // ==========================================
   // scenarios
   task automatic t_reset_regs;
      rd("status", `OFS_STATUS, 32'h0000_1800);
      rd("vector", `OFS_VECTOR, 32'h0);
      rd("enable", `OFS_ENABLE, 32'h0);
      rd("pending", `OFS_PENDING, 32'h0);
      rd("priv", `OFS_PRIV, 32'h3);
      $display("test reset_regs done");
   endtask : t_reset_regs

   task automatic t_access;
      clk_en <= 1'b0;
      wr(`OFS_ENABLE, 32'h0000_0888);
      clk_en <= 1'b1;
      rd("frozen", `OFS_ENABLE, 32'h0);
      wr(`OFS_STATUS, 32'hffff_ffff);
      rd("status", `OFS_STATUS, 32'h0000_1888);
      wr(`OFS_ENABLE, 32'hffff_ffff);
      rd("enable", `OFS_ENABLE, 32'h0000_0888);
      wr(`OFS_PENDING, 32'hffff_ffff);
      rd("pending", `OFS_PENDING, 32'h0);
      wr(`OFS_VECTOR, 32'h0000_1043);
      rd("vector", `OFS_VECTOR, 32'h0000_1040);
      wr(`OFS_VECTOR, 32'h0000_1041);
      rd("vector", `OFS_VECTOR, 32'h0000_1041);
      rd("unmapped", 8'h1c, 32'h0);
      wr(`OFS_STATUS, 32'h0);
      $display("test access done");
   endtask : t_access

   task automatic t_vectored;
      logic [31:0] ofs [3];
      logic [31:0] cause [3];
      logic [2:0] drop [3];
      ofs = '{32'h2c, 32'h0c, 32'h1c};
      cause = '{32'h8000_000b, 32'h8000_0003, 32'h8000_0007};
      drop = '{3'b100, 3'b001, 3'b010};
      cur_pc <= 32'h0000_0400;
      want <= 3'b111;
      quiet(6);
      rd("pending", `OFS_PENDING, 32'h0000_0888);
      wr(`OFS_STATUS, 32'h8);
      for (int i = 0; i < 3; i++) begin
         wait_redirect("irq", 32'h1040 + ofs[i]);
         rd("cause", `OFS_CAUSE, cause[i]);
         rd("status", `OFS_STATUS, 32'h0000_1880);
         quiet(8);
         want <= want & ~drop[i];
         repeat (4) @(posedge ref_clk);
         cur_pc <= 32'h0000_0410 + 32'h10 * i;
         do_ret(32'h0000_0400 + 32'h10 * i);
      end
      $display("test vectored done");
   endtask : t_vectored

   task automatic t_direct;
      int n;
      wr(`OFS_STATUS, 32'h0);
      do_ret(32'h0000_0420);
      wr(`OFS_STATUS, 32'h0000_1800);
      wr(`OFS_VECTOR, 32'h0000_0800);
      cur_pc <= 32'h0000_0600;
      exc_code <= 10'h002;
      @(posedge ref_clk);
      exc_req <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (trap_busy !== 1'b1 && n < 20);
      exc_req <= 1'b0;
      wait_redirect("exc target", 32'h0000_0800);
      rd("status", `OFS_STATUS, 32'h0);
      rd("cause", `OFS_CAUSE, 32'h0000_0002);
      rd("ret pc", `OFS_RET_PC, 32'h0000_0600);
      rd("priv", `OFS_PRIV, 32'h3);
      want <= 3'b100;
      wr(`OFS_ENABLE, 32'h0000_0088);
      quiet(10);
      wr(`OFS_STATUS, 32'h8);
      quiet(10);
      wr(`OFS_ENABLE, 32'h0000_0888);
      wait_redirect("direct irq", 32'h0000_0800);
      rd("cause", `OFS_CAUSE, 32'h8000_000b);
      want <= 3'b000;
      repeat (4) @(posedge ref_clk);
      do_ret(32'h0000_0600);
      $display("test direct done");
   endtask : t_direct

   // ==========================================
   // clock, sequence, watchdog and verdict
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      want = 3'h0;
      cur_pc = 32'h0;
      exc_req = 1'b0;
      exc_code = 10'h0;
      ret_req = 1'b0;
      n_mismatch = 0;
      num_checks = 0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset_regs();
      t_access();
      t_vectored();
      t_direct();
      end_of_test();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      end_of_test();
   end
endmodule : test_machine_trap_entry_exit
